// File: hdl/rcc_pkg.sv
// shared constants and carriers for the regulator control/configuration register bank
// assumes: byte-wide registers reached by the serial control port front end on the system clock
package rcc_pkg;

   // ****************************************
   // register map and reset values
   // ****************************************
   localparam logic [7:0] CH2_CONTROL_OFS = 8'h06;
   localparam logic [7:0] CH2_CONFIG_OFS  = 8'h07;
   localparam logic [7:0] CH3_CONTROL_OFS = 8'h08;
   localparam logic [7:0] CH3_CONFIG_OFS  = 8'h09;
   localparam logic [7:0] CONTROL_RESET   = 8'h22;
   localparam logic [7:0] CONFIG_RESET    = 8'h22;
   localparam logic [7:0] UNMAPPED_READ   = 8'h00;

   // ****************************************
   // field positions
   // ****************************************
   localparam int RESIDUAL_BIT   = 7;
   localparam int PULLDOWN_BIT   = 5;
   localparam int MONITOR_BIT    = 4;
   localparam int VOUT_SEL_BIT   = 3;
   localparam int MULTIPHASE_BIT = 2;
   localparam int FORCE_PWM_BIT  = 1;
   localparam int ENABLE_BIT     = 0;
   localparam int ILIM_LSB       = 3;
   localparam int SLEW_LSB       = 0;

   // ****************************************
   // field codes
   // ****************************************
   localparam logic [2:0] ILIM_MIN_CODE = 3'h2;   // codes below are reserved
   localparam logic [2:0] ILIM_RESET    = 3'h4;
   localparam logic [2:0] SLEW_RESET    = 3'h2;

   // decoded settings handed to one regulator channel
   typedef struct packed {
      logic       residual_check_sel;
      logic       pulldown_en;
      logic       monitor_en;
      logic       vout_reg_sel;
      logic       force_multiphase;
      logic       force_pwm;
      logic       regulator_en;
      logic [2:0] peak_current_limit;
      logic [2:0] slew_sel;
   } rcc_chan_s;

   // register access request from the serial port front end
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rcc_req_s;

endpackage : rcc_pkg

// File: hdl/rcc_regs.sv
// control and configuration registers of the second and third step-down channels
// assumes: requests arrive from the serial port front end on clock, one per cycle at most
//
// Overview of operation
// - Control bit 7 switches residual voltage checking of the channel feedback pin on or off.
// - Control bit 5 connects the output pull-down while the channel is off, and resets to one.
// - Control bit 4 enables all four protection comparators of the channel together.
// - Control bit 3 picks the first (0) or second (1) output voltage register as target.
// - Control bit 1 forces fixed PWM when one, otherwise automatic PFM/PWM, and resets to one.
// - Control bit 0 turns the regulator on when one, and resets to zero.
// - Only the third channel uses control bit 2 to force multi-phase PWM; on the second it is reserved.
// - Config bits 5:3 set peak current limit, codes 2..7 for 2.5 A..7.5 A, reset code 4.
// - The peak current limit can be rewritten at any time and takes effect while running.
// - The effective current limit may be capped below the written code by device settings.
// - Config bits 2:0 select the slew rate from 33 down to 0.31 mV/us, reset code 2.
// - The second channel control sits at 0x6 and config at 0x7, both resetting to 0x22.
// - The third channel control sits at 0x8 and config at 0x9, both resetting to 0x22.
// - The registers are reachable from the host over either serial control port.
`timescale 1ns/1ns
`default_nettype none

module rcc_regs #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clock,
   input  wire logic              sys_rst,
   input  wire rcc_pkg::rcc_req_s req,
   input  wire logic [2:0]        ilim_cap,
   output logic [7:0]             rd_data,
   output logic                   rd_valid,
   output rcc_pkg::rcc_chan_s     ch2_out,
   output rcc_pkg::rcc_chan_s     ch3_out
);

   // ****************************************
   // elaboration check
   // ****************************************
   if (ADDR_W != 8) begin : g_bad_addr
      $error("rcc_regs: ADDR_W must be 8");
   end

   typedef struct packed {
      logic [7:0]         ch2_control;
      logic [7:0]         ch2_config;
      logic [7:0]         ch3_control;
      logic [7:0]         ch3_config;
      logic [7:0]         rd_data;
      logic               rd_valid;
      rcc_pkg::rcc_chan_s ch2;
      rcc_pkg::rcc_chan_s ch3;
   } rcc_state_s;

   rcc_state_s st;
   rcc_state_s next_st;

   // ****************************************
   // decode one channel's register pair
   // ****************************************
   function automatic rcc_pkg::rcc_chan_s decode_chan(
      input logic [7:0] ctrl,
      input logic [7:0] conf,
      input logic [2:0] cap,
      input logic       mp_ok
   );
      rcc_pkg::rcc_chan_s c;
      logic [2:0]         lim;
      c.residual_check_sel = ctrl[rcc_pkg::RESIDUAL_BIT];
      c.pulldown_en        = ctrl[rcc_pkg::PULLDOWN_BIT];
      c.monitor_en         = ctrl[rcc_pkg::MONITOR_BIT];
      c.vout_reg_sel       = ctrl[rcc_pkg::VOUT_SEL_BIT];
      c.force_multiphase   = mp_ok & ctrl[rcc_pkg::MULTIPHASE_BIT];
      c.force_pwm          = ctrl[rcc_pkg::FORCE_PWM_BIT];
      c.regulator_en       = ctrl[rcc_pkg::ENABLE_BIT];
      lim = conf[rcc_pkg::ILIM_LSB +: 3];
      // reserved codes would mean no defined limit, so hold the lowest one
      if (lim < rcc_pkg::ILIM_MIN_CODE) begin
         lim = rcc_pkg::ILIM_MIN_CODE;
      end
      // device settings may cap the usable limit; a reserved cap is ignored
      if (cap >= rcc_pkg::ILIM_MIN_CODE && lim > cap) begin
         lim = cap;
      end
      c.peak_current_limit = lim;
      c.slew_sel           = conf[rcc_pkg::SLEW_LSB +: 3];
      return c;
   endfunction

   // ****************************************
   // next state: writes, read answer, decode
   // ****************************************
   always_comb begin
      next_st = st;
      next_st.rd_valid = req.rd;
      next_st.rd_data  = rcc_pkg::UNMAPPED_READ;
      // write decode; unmapped writes fall through and are dropped
      if (req.wr) begin
         if (req.addr == rcc_pkg::CH2_CONTROL_OFS) begin
            next_st.ch2_control = req.wdata;
         end else if (req.addr == rcc_pkg::CH2_CONFIG_OFS) begin
            next_st.ch2_config = req.wdata;
         end else if (req.addr == rcc_pkg::CH3_CONTROL_OFS) begin
            next_st.ch3_control = req.wdata;
         end else if (req.addr == rcc_pkg::CH3_CONFIG_OFS) begin
            next_st.ch3_config = req.wdata;
         end
      end
      // read decode returns the stored byte, reserved bits included
      if (req.rd) begin
         if (req.addr == rcc_pkg::CH2_CONTROL_OFS) begin
            next_st.rd_data = st.ch2_control;
         end else if (req.addr == rcc_pkg::CH2_CONFIG_OFS) begin
            next_st.rd_data = st.ch2_config;
         end else if (req.addr == rcc_pkg::CH3_CONTROL_OFS) begin
            next_st.rd_data = st.ch3_control;
         end else if (req.addr == rcc_pkg::CH3_CONFIG_OFS) begin
            next_st.rd_data = st.ch3_config;
         end
      end
      // decode from the next values so outputs follow a write on the same edge
      next_st.ch2 = decode_chan(next_st.ch2_control, next_st.ch2_config, ilim_cap, 1'b0);
      next_st.ch3 = decode_chan(next_st.ch3_control, next_st.ch3_config, ilim_cap, 1'b1);
      if (sys_rst) begin
         next_st.ch2_control = rcc_pkg::CONTROL_RESET;
         next_st.ch2_config  = rcc_pkg::CONFIG_RESET;
         next_st.ch3_control = rcc_pkg::CONTROL_RESET;
         next_st.ch3_config  = rcc_pkg::CONFIG_RESET;
         next_st.rd_data     = rcc_pkg::UNMAPPED_READ;
         next_st.rd_valid    = 1'b0;
         next_st.ch2 = decode_chan(rcc_pkg::CONTROL_RESET, rcc_pkg::CONFIG_RESET, 3'h0, 1'b0);
         next_st.ch3 = decode_chan(rcc_pkg::CONTROL_RESET, rcc_pkg::CONFIG_RESET, 3'h0, 1'b1);
      end
   end

   // single state register; reset is folded into next_st above
   always_ff @(posedge clock) begin
      st <= next_st;
   end

   assign rd_data  = st.rd_data;
   assign rd_valid = st.rd_valid;
   assign ch2_out  = st.ch2;
   assign ch3_out  = st.ch3;

   // ****************************************
   // assertions
   // ****************************************
   reset_values_a : assert property (@(posedge clock) sys_rst |=>
      (st.ch2_control == 8'h22 && st.ch3_config == 8'h22 && ch2_out.pulldown_en && ch3_out.force_pwm
       && !ch2_out.regulator_en && ch3_out.peak_current_limit == 3'h4 && ch2_out.slew_sel == 3'h2))
      else $error("reset values wrong");

   enable_write_a : assert property (@(posedge clock) disable iff (sys_rst)
      (req.wr && req.addr == 8'h06) |=> ch2_out.regulator_en == $past(req.wdata[0]))
      else $error("ch2 enable does not follow write");

   ch3_control_a : assert property (@(posedge clock) disable iff (sys_rst)
      (req.wr && req.addr == 8'h08) |=> (ch3_out.residual_check_sel == $past(req.wdata[7])
       && ch3_out.monitor_en == $past(req.wdata[4]) && ch3_out.vout_reg_sel == $past(req.wdata[3])))
      else $error("ch3 control fields do not follow write");

   multiphase_ch2_a : assert property (@(posedge clock) disable iff (sys_rst)
      !ch2_out.force_multiphase)
      else $error("ch2 multiphase must stay off");

   multiphase_ch3_a : assert property (@(posedge clock) disable iff (sys_rst)
      ch3_out.force_multiphase == st.ch3_control[2])
      else $error("ch3 multiphase mismatch");

   ilim_range_a : assert property (@(posedge clock) disable iff (sys_rst)
      ch2_out.peak_current_limit >= 3'h2 && ch3_out.peak_current_limit >= 3'h2)
      else $error("reserved current limit code on output");

   ilim_cap_a : assert property (@(posedge clock) disable iff (sys_rst)
      // the edge after a reset shows the reset decode, where the cap was ignored on purpose
      (!$past(sys_rst) && $past(ilim_cap) >= 3'h2) |-> ch3_out.peak_current_limit <= $past(ilim_cap))
      else $error("current limit above cap");

   ilim_running_a : assert property (@(posedge clock) disable iff (sys_rst)
      (ch2_out.regulator_en && req.wr && req.addr == 8'h07 && req.wdata[5:3] >= 3'h2
       && (ilim_cap < 3'h2 || ilim_cap == 3'h7))
      |=> ch2_out.peak_current_limit == $past(req.wdata[5:3]))
      else $error("current limit not updated while running");

   slew_write_a : assert property (@(posedge clock) disable iff (sys_rst)
      (req.wr && req.addr == 8'h09) |=> ch3_out.slew_sel == $past(req.wdata[2:0]))
      else $error("ch3 slew does not follow write");

   read_back_a : assert property (@(posedge clock) disable iff (sys_rst)
      (req.rd && !req.wr && req.addr == 8'h07) |=> (rd_valid && rd_data == $past(st.ch2_config)))
      else $error("read back mismatch");

   // write-follow checks take the request of the taking edge through $past
   ch2_control_a : assert property (@(posedge clock) disable iff (sys_rst)
      (req.wr && req.addr == 8'h06) |=> (ch2_out.residual_check_sel == $past(req.wdata[7])
       && ch2_out.pulldown_en == $past(req.wdata[5]) && ch2_out.monitor_en == $past(req.wdata[4])
       && ch2_out.vout_reg_sel == $past(req.wdata[3]) && ch2_out.force_pwm == $past(req.wdata[1])))
      else $error("ch2 control fields do not follow write");

   ch3_mode_bits_a : assert property (@(posedge clock) disable iff (sys_rst)
      (req.wr && req.addr == 8'h08) |=> (ch3_out.pulldown_en == $past(req.wdata[5])
       && ch3_out.force_pwm == $past(req.wdata[1]) && ch3_out.regulator_en == $past(req.wdata[0])))
      else $error("ch3 mode bits do not follow write");

   ch2_slew_a : assert property (@(posedge clock) disable iff (sys_rst)
      (req.wr && req.addr == 8'h07) |=> ch2_out.slew_sel == $past(req.wdata[2:0]))
      else $error("ch2 slew does not follow write");

   ilim_write_a : assert property (@(posedge clock) disable iff (sys_rst)
      (req.wr && req.addr == 8'h09 && req.wdata[5:3] >= 3'h2 && ilim_cap < 3'h2)
      |=> ch3_out.peak_current_limit == $past(req.wdata[5:3]))
      else $error("ch3 limit does not follow write");

   ch2_cap_a : assert property (@(posedge clock) disable iff (sys_rst)
      (!$past(sys_rst) && $past(ilim_cap) >= 3'h2) |-> ch2_out.peak_current_limit <= $past(ilim_cap))
      else $error("ch2 current limit above cap");

   read_pulse_a : assert property (@(posedge clock) disable iff (sys_rst)
      !$past(sys_rst) |-> rd_valid == $past(req.rd))
      else $error("read valid is not a one-cycle answer");

   unmapped_read_a : assert property (@(posedge clock) disable iff (sys_rst)
      (req.rd && (req.addr < 8'h06 || req.addr > 8'h09)) |=> rd_data == 8'h00)
      else $error("unmapped read not zero");

endmodule : rcc_regs

`default_nettype wire

// File: verification/rcc_regs_tb.sv
// self-checking bench for the channel 2/3 control and configuration register bank
// assumes: rcc_pkg compiled first; requests are one-cycle strobes on the 25 MHz system clock
`timescale 1ns/1ns
`default_nettype none

module rcc_regs_tb;
   logic               clock    = 1'b0;
   logic               sys_rst  = 1'b1;
   rcc_pkg::rcc_req_s  req      = '0;
   logic [2:0]         ilim_cap = 3'h0;
   logic [7:0]         rd_data;
   logic               rd_valid;
   rcc_pkg::rcc_chan_s ch2_out;
   rcc_pkg::rcc_chan_s ch3_out;
   int                 n_mismatch  = 0;
   int                 comparisons = 0;

   // 40 ns period
   always #20 clock = ~clock;

   rcc_regs #(.ADDR_W(8)) dut_u (.clock(clock), .sys_rst(sys_rst), .req(req), .ilim_cap(ilim_cap),
      .rd_data(rd_data), .rd_valid(rd_valid), .ch2_out(ch2_out), .ch3_out(ch3_out));

   // ****************************************
   // shared helpers
   // ****************************************
   // bytes are zero-extended so one compare covers register reads and channel outputs
   task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // expected channel outputs worked out from a control byte and decoded config fields
   function automatic rcc_pkg::rcc_chan_s exp_ch(logic [7:0] c, logic mp, logic [2:0] lim, logic [2:0] slew);
      exp_ch = rcc_pkg::rcc_chan_s'{residual_check_sel: c[7], pulldown_en: c[5], monitor_en: c[4],
         vout_reg_sel: c[3], force_multiphase: mp, force_pwm: c[1], regulator_en: c[0],
         peak_current_limit: lim, slew_sel: slew};
   endfunction

   // strobe held for exactly one edge, outputs settle after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      req.wr    <= 1'b1;
      req.addr  <= a;
      req.wdata <= d;
      @(posedge clock);
      req.wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      req.rd   <= 1'b1;
      req.addr <= a;
      @(posedge clock);
      req.rd <= 1'b0;
      #1;
      chk({12'h000, rd_valid}, 13'h0001, "read valid");
      chk({5'h00, rd_data}, {5'h00, exp}, "read data");
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic test_reset;
      @(posedge clock);
      #1;
      chk(ch2_out, exp_ch(8'h22, 1'b0, 3'h4, 3'h2), "ch2 reset");
      chk(ch3_out, exp_ch(8'h22, 1'b0, 3'h4, 3'h2), "ch3 reset");
      rd(8'h06, 8'h22);
      rd(8'h07, 8'h22);
      rd(8'h08, 8'h22);
      rd(8'h09, 8'h22);
   endtask

   // bit 2 set on both channels: only the third may act on it
   task automatic test_control;
      wr(8'h06, 8'h9d);
      chk(ch2_out, exp_ch(8'h9d, 1'b0, 3'h4, 3'h2), "ch2 control");
      rd(8'h06, 8'h9d);
      wr(8'h08, 8'h5c);
      chk(ch3_out, exp_ch(8'h5c, 1'b1, 3'h4, 3'h2), "ch3 control");
      rd(8'h08, 8'h5c);
   endtask

   // every limit and slew code, reserved limit codes shown as the lowest legal one
   task automatic test_config;
      for (int i = 0; i < 8; i++) begin
         wr(8'h07, {2'b00, i[2:0], i[2:0]});
         chk(ch2_out, exp_ch(8'h9d, 1'b0, (i < 2) ? 3'h2 : i[2:0], i[2:0]), "ch2 config");
      end
      rd(8'h07, 8'h3f);
      wr(8'h08, 8'h01);
      wr(8'h09, 8'h3d);
      chk(ch3_out, exp_ch(8'h01, 1'b0, 3'h7, 3'h5), "limit while running");
      @(posedge clock);
      ilim_cap <= 3'h5;
      repeat (3) @(posedge clock);
      #1;
      chk(ch3_out, exp_ch(8'h01, 1'b0, 3'h5, 3'h5), "capped limit");
      rd(8'h09, 8'h3d);
      @(posedge clock);
      ilim_cap <= 3'h0;
      repeat (3) @(posedge clock);
      #1;
      chk(ch3_out, exp_ch(8'h01, 1'b0, 3'h7, 3'h5), "cap released");
   endtask

   // writes outside the map leave the bank alone, reads give zero
   task automatic test_unmapped;
      wr(8'h0a, 8'hff);
      wr(8'h05, 8'hff);
      rd(8'h0a, 8'h00);
      rd(8'h05, 8'h00);
      rd(8'h06, 8'h9d);
      rd(8'h09, 8'h3d);
   endtask

   // reset in mid-run with a cap standing: reset ignores the cap, the first free edge applies it
   task automatic test_midrun_reset;
      @(posedge clock);
      ilim_cap <= 3'h2;
      sys_rst  <= 1'b1;
      @(posedge clock);
      sys_rst <= 1'b0;
      #1;
      chk(ch3_out, exp_ch(8'h22, 1'b0, 3'h4, 3'h2), "ch3 reset with cap");
      @(posedge clock);
      #1;
      chk(ch3_out, exp_ch(8'h22, 1'b0, 3'h2, 3'h2), "ch3 cap after reset");
      chk(ch2_out, exp_ch(8'h22, 1'b0, 3'h2, 3'h2), "ch2 cap after reset");
      rd(8'h06, 8'h22);
      rd(8'h09, 8'h22);
      @(posedge clock);
      ilim_cap <= 3'h0;
   endtask

   // write and read of one byte in the same cycle: the read answers with the byte from before
   task automatic test_same_cycle;
      @(posedge clock);
      req.wr    <= 1'b1;
      req.rd    <= 1'b1;
      req.addr  <= 8'h07;
      req.wdata <= 8'h1b;
      @(posedge clock);
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      #1;
      chk({5'h00, rd_data}, 13'h0022, "read beside write");
      chk(ch2_out, exp_ch(8'h22, 1'b0, 3'h3, 3'h3), "write beside read");
      rd(8'h07, 8'h1b);
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // main sequence after 3 cycles of reset
   initial begin
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      test_reset();
      test_control();
      test_config();
      test_unmapped();
      test_midrun_reset();
      test_same_cycle();
      tally_and_finish();
   end

   // whole run needs well under 200 cycles
   initial begin
      repeat (2000) @(posedge clock);
      n_mismatch++;
      tally_and_finish();
   end
endmodule // rcc_regs_tb

`default_nettype wire
